// [hdl/frs_pkg.sv]
package frs_pkg;

   // ==========================================================
   // Field positions of the first result byte
   localparam int unsigned RS0_TERM_HI = 7;
   localparam int unsigned RS0_TERM_LO = 6;
   localparam int unsigned RS0_POS_DONE = 5;
   localparam int unsigned RS0_HOME_FAULT = 4;
   localparam int unsigned RS0_SURFACE = 2;
   localparam int unsigned RS0_UNIT_HI = 1;
   localparam int unsigned RS0_UNIT_LO = 0;

   // ==========================================================
   // Field positions of the second result byte
   localparam int unsigned RS1_LAST_SECT = 7;
   localparam int unsigned RS1_CRC_ANY = 5;
   localparam int unsigned RS1_SVC_LATE = 4;
   localparam int unsigned RS1_SECT_ABSENT = 2;
   localparam int unsigned RS1_WR_BLOCKED = 1;
   localparam int unsigned RS1_ID_SYNC = 0;

   // ==========================================================
   // Field positions of the third result byte
   localparam int unsigned RS2_DEL_HIT = 6;
   localparam int unsigned RS2_PAY_CRC = 5;
   localparam int unsigned RS2_TRK_MISMATCH = 4;
   localparam int unsigned RS2_BAD_TRACK = 1;
   localparam int unsigned RS2_PAY_SYNC = 0;

   // ==========================================================
   // Constants
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] BAD_TRACK_ID = 8'hFF;
   localparam logic [7:0] LAST_SECTOR_NUM = 8'hFF;
   localparam logic [6:0] RECAL_STEP_LIMIT = 7'h50;
   localparam logic [1:0] RESULT_IDX_LAST = 2'h2;

   // Termination codes
   typedef enum logic [1:0] {
      FRS_TERM_NORMAL = 2'b00,
      FRS_TERM_ABNORMAL = 2'b01,
      FRS_TERM_INVALID = 2'b10,
      FRS_TERM_POLLING = 2'b11
   } frs_term_t;

   // Command classes the encoder needs to distinguish
   typedef enum logic [2:0] {
      FRS_CMD_OTHER,
      FRS_CMD_READ_DATA,
      FRS_CMD_READ_DELETED,
      FRS_CMD_READ_ID,
      FRS_CMD_READ_TRACK,
      FRS_CMD_WRITE,
      FRS_CMD_RECAL,
      FRS_CMD_REL_SEEK
   } frs_cmd_t;

   // Per-operation context latched at command start
   typedef struct packed {
      frs_cmd_t cmd;
      logic surface;
      logic [1:0] unit;
   } frs_ctx_t;

   // Condition events from the disk-side logic, one-cycle pulses
   typedef struct packed {
      logic seek_done;
      logic step_pulse;
      logic outward_past_zero;
      logic sector_overflow;
      logic id_crc_err;
      logic data_crc_err;
      logic svc_late;
      logic sector_not_found;
      logic id_read_fail;
      logic seq_fail;
      logic id_mark_missing;
      logic data_mark_missing;
      logic deleted_mark_seen;
      logic normal_mark_seen;
      logic id_track_valid;
      logic [7:0] id_track;
   } frs_evt_t;

endpackage : frs_pkg

// [hdl/frs_result_encoder.sv]
`timescale 1ns/1ps

module frs_result_encoder (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Command sequencing
   input wire logic cmd_start,
   input wire frs_pkg::frs_ctx_t cmd_ctx,
   input wire logic cmd_invalid,
   input wire logic cmd_finish,
   input wire logic cmd_abort_poll,
   input wire logic transfer_last,
   input wire logic [7:0] internal_track,
   // Condition events from the disk side
   input wire frs_pkg::frs_evt_t evt,
   // Drive pins
   input wire logic home_track_sense,
   input wire logic media_locked_sense,
   input wire logic rotation_pulse_n,
   // Result byte port, paced by the host handshake
   input wire logic result_rd,
   output logic host_may_transfer,
   output logic transfer_direction,
   output logic [7:0] result_byte,
   output logic result_done
);

   // ==========================================================
   // Pin synchronisers
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic [2:0] pin_meta_next;
   logic [2:0] pin_sync_next;
   logic lock_prev_reg;
   logic lock_prev_next;
   logic idx_prev_reg;
   logic idx_prev_next;

   // Second flop is the only reader of the first
   always_comb begin
      pin_meta_next = {home_track_sense, media_locked_sense, rotation_pulse_n};
      pin_sync_next = pin_meta_reg;
      lock_prev_next = pin_sync_reg[1];
      idx_prev_next = pin_sync_reg[0];
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_reg <= 3'h7;
         pin_sync_reg <= 3'h7;
         lock_prev_reg <= 1'b1;
         idx_prev_reg <= 1'b1;
      end else begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
         lock_prev_reg <= lock_prev_next;
         idx_prev_reg <= idx_prev_next;
      end
   end

   logic home_s;
   logic lock_rise;
   logic idx_fall;
   assign home_s = pin_sync_reg[2];
   assign lock_rise = pin_sync_reg[1] && !lock_prev_reg;
   assign idx_fall = !pin_sync_reg[0] && idx_prev_reg;

   // ==========================================================
   // Status accumulation during execution
   typedef enum logic [1:0] {
      FRS_IDLE,
      FRS_EXEC,
      FRS_RESULT
   } frs_state_t;

   frs_state_t state_reg;
   frs_state_t state_next;
   frs_pkg::frs_ctx_t ctx_reg;
   frs_pkg::frs_ctx_t ctx_next;
   frs_pkg::frs_term_t term_reg;
   frs_pkg::frs_term_t term_next;
   logic [7:0] rs0_reg;
   logic [7:0] rs0_next;
   logic [7:0] rs1_reg;
   logic [7:0] rs1_next;
   logic [7:0] rs2_reg;
   logic [7:0] rs2_next;
   logic [6:0] steps_reg;
   logic [6:0] steps_next;
   logic [1:0] idx_cnt_reg;
   logic [1:0] idx_cnt_next;
   logic id_seen_reg;
   logic id_seen_next;
   logic [1:0] rd_idx_reg;
   logic [1:0] rd_idx_next;
   logic [7:0] byte_reg;
   logic [7:0] byte_next;
   logic done_reg;
   logic done_next;
   logic any_fault;

   // Flags are sticky within one command; cleared only by the next start
   always_comb begin
      state_next = state_reg;
      ctx_next = ctx_reg;
      term_next = term_reg;
      rs0_next = rs0_reg;
      rs1_next = rs1_reg;
      rs2_next = rs2_reg;
      steps_next = steps_reg;
      idx_cnt_next = idx_cnt_reg;
      id_seen_next = id_seen_reg;
      rd_idx_next = rd_idx_reg;
      byte_next = byte_reg;
      done_next = 1'b0;
      any_fault = 1'b0;
      case (state_reg)
         FRS_IDLE: begin
            if (cmd_start) begin
               state_next = FRS_EXEC;
               ctx_next = cmd_ctx;
               rs0_next = frs_pkg::STATUS_RESET;
               rs1_next = frs_pkg::STATUS_RESET;
               rs2_next = frs_pkg::STATUS_RESET;
               steps_next = '0;
               idx_cnt_next = '0;
               id_seen_next = 1'b0;
               term_next = frs_pkg::FRS_TERM_NORMAL;
               if (cmd_invalid) begin
                  term_next = frs_pkg::FRS_TERM_INVALID;
                  state_next = FRS_RESULT;
                  rd_idx_next = '0;
               end
            end
         end
         FRS_EXEC: begin
            if (evt.seek_done) begin
               rs0_next[frs_pkg::RS0_POS_DONE] = 1'b1;
            end
            if (ctx_reg.cmd == frs_pkg::FRS_CMD_RECAL && evt.step_pulse && !home_s) begin
               if (steps_reg == frs_pkg::RECAL_STEP_LIMIT - 7'h01) begin
                  rs0_next[frs_pkg::RS0_HOME_FAULT] = 1'b1;
               end else begin
                  steps_next = steps_reg + 7'h01;
               end
            end
            if (ctx_reg.cmd == frs_pkg::FRS_CMD_REL_SEEK && evt.outward_past_zero) begin
               rs0_next[frs_pkg::RS0_HOME_FAULT] = 1'b1;
            end
            if (evt.sector_overflow) begin
               rs1_next[frs_pkg::RS1_LAST_SECT] = 1'b1;
            end
            if (evt.id_crc_err || evt.data_crc_err) begin
               rs1_next[frs_pkg::RS1_CRC_ANY] = 1'b1;
            end
            if (evt.data_crc_err) begin
               rs2_next[frs_pkg::RS2_PAY_CRC] = 1'b1;
            end
            if (evt.svc_late) begin
               rs1_next[frs_pkg::RS1_SVC_LATE] = 1'b1;
            end
            // Each cause only counts for the command that can raise it
            if ((evt.sector_not_found && (ctx_reg.cmd == frs_pkg::FRS_CMD_READ_DATA
                  || ctx_reg.cmd == frs_pkg::FRS_CMD_READ_DELETED))
                  || (evt.id_read_fail && ctx_reg.cmd == frs_pkg::FRS_CMD_READ_ID)
                  || (evt.seq_fail && ctx_reg.cmd == frs_pkg::FRS_CMD_READ_TRACK)) begin
               rs1_next[frs_pkg::RS1_SECT_ABSENT] = 1'b1;
            end
            if (lock_rise && ctx_reg.cmd == frs_pkg::FRS_CMD_WRITE) begin
               rs1_next[frs_pkg::RS1_WR_BLOCKED] = 1'b1;
            end
            // Two index pulses with no ID mark seen means the mark is missing
            if (evt.id_track_valid) begin
               id_seen_next = 1'b1;
            end
            if (idx_fall && !id_seen_reg && idx_cnt_reg != 2'h2) begin
               idx_cnt_next = idx_cnt_reg + 2'h1;
            end
            if ((idx_fall && !id_seen_reg && idx_cnt_reg == 2'h1) || evt.id_mark_missing
                  || evt.data_mark_missing) begin
               rs1_next[frs_pkg::RS1_ID_SYNC] = 1'b1;
            end
            if (evt.data_mark_missing) begin
               rs2_next[frs_pkg::RS2_PAY_SYNC] = 1'b1;
            end
            if ((ctx_reg.cmd == frs_pkg::FRS_CMD_READ_DATA && evt.deleted_mark_seen)
                  || (ctx_reg.cmd == frs_pkg::FRS_CMD_READ_DELETED && evt.normal_mark_seen)) begin
               rs2_next[frs_pkg::RS2_DEL_HIT] = 1'b1;
            end
            if (evt.id_track_valid && evt.id_track != internal_track) begin
               rs2_next[frs_pkg::RS2_TRK_MISMATCH] = 1'b1;
               if (evt.id_track == frs_pkg::BAD_TRACK_ID) begin
                  rs2_next[frs_pkg::RS2_BAD_TRACK] = 1'b1;
               end
            end
            // Judge from the next values so a fault in the finish cycle still counts
            any_fault = (rs1_next != frs_pkg::STATUS_RESET)
               || (rs2_next != frs_pkg::STATUS_RESET)
               || rs0_next[frs_pkg::RS0_HOME_FAULT];
            if (cmd_abort_poll) begin
               term_next = frs_pkg::FRS_TERM_POLLING;
               state_next = FRS_RESULT;
               rd_idx_next = '0;
            end else if (cmd_finish) begin
               // Read data and write commands that run out without transfer_last overran the track
               if (!transfer_last && (ctx_reg.cmd == frs_pkg::FRS_CMD_READ_DATA
                     || ctx_reg.cmd == frs_pkg::FRS_CMD_WRITE)) begin
                  rs1_next[frs_pkg::RS1_LAST_SECT] = 1'b1;
                  term_next = frs_pkg::FRS_TERM_ABNORMAL;
               end else if (any_fault) begin
                  term_next = frs_pkg::FRS_TERM_ABNORMAL;
               end else begin
                  term_next = frs_pkg::FRS_TERM_NORMAL;
               end
               state_next = FRS_RESULT;
               rd_idx_next = '0;
            end
         end
         FRS_RESULT: begin
            // Byte order 0,1,2; each host read advances the index, and the read of byte 2 ends the phase instead
            case (rd_idx_reg)
               2'h0: byte_next = {term_reg, rs0_reg[frs_pkg::RS0_POS_DONE],
                  rs0_reg[frs_pkg::RS0_HOME_FAULT], 1'b0, ctx_reg.surface,
                  ctx_reg.unit};
               2'h1: byte_next = {rs1_reg[frs_pkg::RS1_LAST_SECT], 1'b0,
                  rs1_reg[frs_pkg::RS1_CRC_ANY], rs1_reg[frs_pkg::RS1_SVC_LATE], 1'b0,
                  rs1_reg[frs_pkg::RS1_SECT_ABSENT], rs1_reg[frs_pkg::RS1_WR_BLOCKED],
                  rs1_reg[frs_pkg::RS1_ID_SYNC]};
               default: byte_next = {1'b0, rs2_reg[frs_pkg::RS2_DEL_HIT],
                  rs2_reg[frs_pkg::RS2_PAY_CRC], rs2_reg[frs_pkg::RS2_TRK_MISMATCH],
                  2'b00, rs2_reg[frs_pkg::RS2_BAD_TRACK],
                  rs2_reg[frs_pkg::RS2_PAY_SYNC]};
            endcase
            if (result_rd) begin
               if (rd_idx_reg == frs_pkg::RESULT_IDX_LAST) begin
                  state_next = FRS_IDLE;
                  done_next = 1'b1;
               end else begin
                  rd_idx_next = rd_idx_reg + 2'h1;
               end
            end
         end
         default: state_next = FRS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= FRS_IDLE;
         ctx_reg <= '0;
         term_reg <= frs_pkg::FRS_TERM_NORMAL;
         rs0_reg <= frs_pkg::STATUS_RESET;
         rs1_reg <= frs_pkg::STATUS_RESET;
         rs2_reg <= frs_pkg::STATUS_RESET;
         steps_reg <= '0;
         idx_cnt_reg <= '0;
         id_seen_reg <= 1'b0;
         rd_idx_reg <= '0;
         byte_reg <= frs_pkg::STATUS_RESET;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ctx_reg <= ctx_next;
         term_reg <= term_next;
         rs0_reg <= rs0_next;
         rs1_reg <= rs1_next;
         rs2_reg <= rs2_next;
         steps_reg <= steps_next;
         idx_cnt_reg <= idx_cnt_next;
         id_seen_reg <= id_seen_next;
         rd_idx_reg <= rd_idx_next;
         byte_reg <= byte_next;
         done_reg <= done_next;
      end
   end

   // ==========================================================
   // Host handshake: the bytes leave only through this sequence
   // Byte is valid one cycle after entry to result phase, so ready waits for it
   logic byte_valid_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         byte_valid_reg <= 1'b0;
      end else begin
         byte_valid_reg <= (state_reg == FRS_RESULT) && !result_rd;
      end
   end

   assign host_may_transfer = byte_valid_reg && (state_reg == FRS_RESULT);
   assign transfer_direction = (state_reg == FRS_RESULT);
   assign result_byte = byte_reg;
   assign result_done = done_reg;

endmodule : frs_result_encoder

// [testbench/frs_result_encoder_checker.sv]
`timescale 1ns/1ps

// ==========================================================
// Result port checker
module frs_result_encoder_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Result byte port
   input wire logic result_rd,
   input wire logic host_may_transfer,
   input wire logic transfer_direction,
   input wire logic [7:0] result_byte,
   input wire logic result_done
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   logic [1:0] idx_reg;
   logic [1:0] idx_next;
   logic take;

   // A read only counts when the byte was on offer
   assign take = result_rd && host_may_transfer;

   // Index of the byte on offer, wraps after the third read
   always_comb begin
      idx_next = idx_reg;
      if (take) begin
         idx_next = (idx_reg == 2'h2) ? 2'h0 : idx_reg + 2'h1;
      end
   end

   // Index register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         idx_reg <= 2'h0;
      end else begin
         idx_reg <= idx_next;
      end
   end

   sequence s_take_mid;
      take && idx_reg != 2'h2;
   endsequence
   sequence s_take_last;
      take && idx_reg == 2'h2;
   endsequence
   sequence s_refill;
      !host_may_transfer ##1 host_may_transfer;
   endsequence

   ready_dir_a: assert property (host_may_transfer |-> transfer_direction)
      else $error("byte offered without outward direction");
   phase_ready_a: assert property ($rose(transfer_direction) |-> ##1 host_may_transfer)
      else $error("result phase began without a byte");
   byte_refill_a: assert property (s_take_mid |=> s_refill)
      else $error("next result byte not offered in time");
   byte_hold_a: assert property (host_may_transfer && !result_rd |=> $stable(result_byte))
      else $error("result byte changed before it was read");
   last_done_a: assert property (s_take_last |=> result_done ##1 !result_done)
      else $error("no single done pulse after third byte");
   done_idle_a: assert property (result_done |-> !host_may_transfer)
      else $error("done pulse while a byte is offered");
   zero_first_a: assert property (host_may_transfer && idx_reg == 2'h0 |-> !result_byte[3])
      else $error("unused bit set in first byte");
   zero_second_a: assert property (host_may_transfer && idx_reg == 2'h1 |->
      (result_byte & 8'h48) == 8'h00)
      else $error("unused bit set in second byte");
   zero_third_a: assert property (host_may_transfer && idx_reg == 2'h2 |->
      (result_byte & 8'h8C) == 8'h00)
      else $error("unused bit set in third byte");
   bad_track_a: assert property (host_may_transfer && idx_reg == 2'h2 && result_byte[1]
      |-> result_byte[4])
      else $error("bad track flag without track mismatch");
endmodule : frs_result_encoder_checker

// [testbench/frs_host_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Host that polls the result port and reads bytes
module frs_host_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Device result port
   input wire logic host_may_transfer,
   input wire logic transfer_direction,
   input wire logic [7:0] result_byte,
   output logic result_rd,
   // Pace and report
   input wire logic slow,
   output logic got,
   output logic [7:0] got_byte
);
   logic [1:0] wait_reg;

   // Read only on ready with outward direction; slow mode lets the byte sit a while
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         result_rd <= 1'b0;
         got <= 1'b0;
         got_byte <= 8'h00;
         wait_reg <= 2'h0;
      end else begin
         got <= 1'b0;
         if (result_rd) begin
            result_rd <= 1'b0;
            got <= 1'b1;
            got_byte <= result_byte;
         end else if (host_may_transfer && transfer_direction) begin
            if (wait_reg != 2'h0) begin
               wait_reg <= wait_reg - 2'h1;
            end else begin
               result_rd <= 1'b1;
               wait_reg <= slow ? 2'h3 : 2'h0;
            end
         end
      end
   end
endmodule : frs_host_model

// [testbench/tb.sv]
`timescale 1ns/1ps

// ==========================================================
// Bench top
module tb;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic cmd_start = 1'b0;
   frs_pkg::frs_ctx_t cmd_ctx = '0;
   logic cmd_invalid = 1'b0;
   logic cmd_finish = 1'b0;
   logic cmd_abort_poll = 1'b0;
   logic transfer_last = 1'b0;
   logic [7:0] internal_track = 8'h10;
   frs_pkg::frs_evt_t evt = '0;
   logic media_locked_sense = 1'b0;
   logic home_track_sense = 1'b0;
   logic rotation_pulse_n = 1'b1;
   logic slow = 1'b0;
   logic result_rd;
   logic host_may_transfer;
   logic transfer_direction;
   logic [7:0] result_byte;
   logic result_done;
   logic got;
   logic [7:0] got_byte;
   logic [7:0] exp_q[$];
   int num_errors = 0;
   int compares = 0;

   always #50 clk_sys = ~clk_sys;

   frs_result_encoder u_frs_result_encoder (
      .clk_sys(clk_sys), .arst_n(arst_n), .cmd_start(cmd_start), .cmd_ctx(cmd_ctx),
      .cmd_invalid(cmd_invalid), .cmd_finish(cmd_finish), .cmd_abort_poll(cmd_abort_poll),
      .transfer_last(transfer_last), .internal_track(internal_track), .evt(evt),
      .home_track_sense(home_track_sense), .media_locked_sense(media_locked_sense),
      .rotation_pulse_n(rotation_pulse_n), .result_rd(result_rd),
      .host_may_transfer(host_may_transfer),
      .transfer_direction(transfer_direction), .result_byte(result_byte),
      .result_done(result_done));

   frs_host_model u_frs_host_model (
      .clk_sys(clk_sys), .arst_n(arst_n), .host_may_transfer(host_may_transfer),
      .transfer_direction(transfer_direction), .result_byte(result_byte),
      .result_rd(result_rd), .slow(slow), .got(got), .got_byte(got_byte));

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // Each byte the host reads is matched with the oldest note
   always @(posedge clk_sys) begin
      if (got === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(got_byte, 8'hxx);
         end else begin
            check(got_byte, exp_q.pop_front());
         end
      end
   end

   // One command; mode 1 invalid, 2 polling abort, 3 no last transfer, 4 media lock,
   // 5 home track sensed, 6 one index pulse per event slot
   task automatic run(input frs_pkg::frs_cmd_t c, input int mode, input logic [22:0] ev,
                      input int n, input logic [7:0] b0, input logic [7:0] b1,
                      input logic [7:0] b2);
      logic [2:0] su;
      int k;
      su = 3'($urandom);
      slow <= 1'($urandom);
      cmd_ctx <= {c, su};
      cmd_invalid <= (mode == 1);
      cmd_start <= 1'b1;
      exp_q.push_back(b0 | {5'h00, su});
      exp_q.push_back(b1);
      exp_q.push_back(b2);
      @(posedge clk_sys);
      cmd_start <= 1'b0;
      cmd_invalid <= 1'b0;
      media_locked_sense <= (mode == 4);
      home_track_sense <= (mode == 5);
      repeat (n) begin
         evt <= ev;
         rotation_pulse_n <= (mode != 6);
         @(posedge clk_sys);
         evt <= '0;
         rotation_pulse_n <= 1'b1;
         @(posedge clk_sys);
      end
      media_locked_sense <= 1'b0;
      home_track_sense <= 1'b0;
      if (mode != 1) begin
         cmd_finish <= (mode != 2);
         cmd_abort_poll <= (mode == 2);
         transfer_last <= (mode != 3);
         @(posedge clk_sys);
         cmd_finish <= 1'b0;
         cmd_abort_poll <= 1'b0;
      end
      for (k = 0; k < 300 && exp_q.size() != 0; k++) begin
         @(posedge clk_sys);
      end
      if (exp_q.size() != 0) begin
         num_errors++;
         close_out();
      end
      // Let the done pulse pass so the next start lands in idle
      repeat (4) @(posedge clk_sys);
      $display("test done at %0t", $time);
   endtask : run

   // Event words follow the packed field order, seek_done on the top bit
   initial begin
      void'($urandom(32'hcf38_61d8));
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      run(frs_pkg::FRS_CMD_OTHER, 1, 23'h00_0000, 0, 8'h80, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_OTHER, 0, 23'h00_0000, 0, 8'h00, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_REL_SEEK, 0, 23'h40_0000, 1, 8'h20, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_OTHER, 2, 23'h00_0000, 0, 8'hC0, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_RECAL, 0, 23'h20_0000, 80, 8'h50, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_RECAL, 5, 23'h20_0000, 80, 8'h00, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_REL_SEEK, 0, 23'h10_0000, 1, 8'h50, 8'h00, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 3, 23'h00_0000, 0, 8'h40, 8'h80, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h08_0000, 1, 8'h40, 8'h80, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h04_0000, 1, 8'h40, 8'h20, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h02_0000, 1, 8'h40, 8'h20, 8'h20);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h01_0000, 1, 8'h40, 8'h10, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h00_8000, 1, 8'h40, 8'h04, 8'h00);
      run(frs_pkg::FRS_CMD_READ_ID, 0, 23'h00_4000, 1, 8'h40, 8'h04, 8'h00);
      run(frs_pkg::FRS_CMD_READ_TRACK, 0, 23'h00_2000, 1, 8'h40, 8'h04, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h00_1000, 1, 8'h40, 8'h01, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 6, 23'h00_0000, 2, 8'h40, 8'h01, 8'h00);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h00_0800, 1, 8'h40, 8'h01, 8'h01);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h00_0400, 1, 8'h40, 8'h00, 8'h40);
      run(frs_pkg::FRS_CMD_READ_DELETED, 0, 23'h00_0200, 1, 8'h40, 8'h00, 8'h40);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h00_0111, 1, 8'h40, 8'h00, 8'h10);
      run(frs_pkg::FRS_CMD_READ_DATA, 0, 23'h00_01FF, 1, 8'h40, 8'h00, 8'h12);
      run(frs_pkg::FRS_CMD_WRITE, 4, 23'h00_0000, 4, 8'h40, 8'h02, 8'h00);
      close_out();
   end
endmodule : tb

bind frs_result_encoder frs_result_encoder_checker u_frs_result_encoder_checker (
   .clk_sys(clk_sys), .arst_n(arst_n), .result_rd(result_rd),
   .host_may_transfer(host_may_transfer), .transfer_direction(transfer_direction),
   .result_byte(result_byte), .result_done(result_done));
